// ===== design/gst_gate.v
`include "gst_timer_consts.vh"
module gst_gate (
    // Clock and reset.
    input wire clk_in,
    input wire rst_n_in,
    // Gate sources, already in the core domain.
    input wire [1:0] sel_in,
    input wire pin_in,
    input wire t0_in,
    input wire cmp1_in,
    input wire cmp2_in,
    // Settings.
    input wire on_in,
    input wire pol_in,
    input wire tm_in,
    input wire spm_in,
    input wire arm_in,
    // Gate level and single-pulse completion.
    output wire val_out,
    output wire arm_clr_out
);
    reg src;
    reg src_d_reg;
    reg tff_reg;
    reg act_d_reg;
    reg run_reg;
    reg arm_clr_reg;
    wire gated;
    wire active;

    // Source selection.
    always @* begin
        case (sel_in)
            `GST_GS_PIN: src = pin_in;
            `GST_GS_T0: src = t0_in;
            `GST_GS_C1: src = cmp1_in;
            `GST_GS_C2: src = cmp2_in;
            default: src = pin_in;
        endcase
    end

    assign gated = tm_in ? tff_reg : src;
    assign active = pol_in ? gated : ~gated;

    // Toggle flip-flop and single-pulse sequencer.
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            src_d_reg <= 1'b0;
            tff_reg <= 1'b0;
            act_d_reg <= 1'b0;
            run_reg <= 1'b0;
            arm_clr_reg <= 1'b0;
        end else begin
            src_d_reg <= src;
            act_d_reg <= active;
            arm_clr_reg <= 1'b0;
            if (!tm_in || !on_in) begin
                tff_reg <= 1'b0;
            end else if (src && !src_d_reg) begin
                tff_reg <= ~tff_reg;
            end
            if (!spm_in || !on_in) begin
                run_reg <= 1'b0;
            end else if (!run_reg && arm_in && active && !act_d_reg) begin
                run_reg <= 1'b1;
            end else if (run_reg && !active) begin
                run_reg <= 1'b0;
                arm_clr_reg <= 1'b1;
            end
        end
    end

    // Single pulse passes only the armed window.
    assign val_out = spm_in ? (run_reg & active) : active;
    assign arm_clr_out = arm_clr_reg;
endmodule

// ===== design/gst_sync2.v
module gst_sync2 #(
    parameter W = 1
) (
    // Clock and reset.
    input wire clk_in,
    input wire rst_n_in,
    // Asynchronous levels and their synchronised copies.
    input wire [W-1:0] async_in,
    output wire [W-1:0] sync_out
);
    reg [W-1:0] meta_reg;
    reg [W-1:0] sync_reg;

    // Two flip-flop chain; only the second stage is visible outside.
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            meta_reg <= {W{1'b0}};
            sync_reg <= {W{1'b0}};
        end else begin
            meta_reg <= async_in;
            sync_reg <= meta_reg;
        end
    end

    assign sync_out = sync_reg;
endmodule

// ===== design/gst_timer.v
// Implementation choices: the AXI4-Lite register port and the address map.
`include "gst_timer_consts.vh"
module gst_timer (
    // Clock and reset.
    input wire core_clk_in,
    input wire rstn_in,
    // AXI4-Lite write address.
    input wire s_axi_awvalid_in,
    output reg s_axi_awready_out,
    input wire [`GST_AW-1:0] s_axi_awaddr_in,
    input wire [2:0] s_axi_awprot_in,
    // AXI4-Lite write data.
    input wire s_axi_wvalid_in,
    output reg s_axi_wready_out,
    input wire [31:0] s_axi_wdata_in,
    input wire [3:0] s_axi_wstrb_in,
    // AXI4-Lite write response.
    output reg s_axi_bvalid_out,
    input wire s_axi_bready_in,
    output reg [1:0] s_axi_bresp_out,
    // AXI4-Lite read address.
    input wire s_axi_arvalid_in,
    output reg s_axi_arready_out,
    input wire [`GST_AW-1:0] s_axi_araddr_in,
    input wire [2:0] s_axi_arprot_in,
    // AXI4-Lite read data.
    output reg s_axi_rvalid_out,
    input wire s_axi_rready_in,
    output reg [31:0] s_axi_rdata_out,
    output reg [1:0] s_axi_rresp_out,
    // Pins from outside the core domain.
    input wire ext_clk_in,
    input wire gate_pin_in,
    input wire cmp1_in,
    input wire cmp2_in,
    // Same-domain neighbours.
    input wire sleep_in,
    input wire [7:0] small_timer_count_in,
    input wire capture_evt_in,
    // Results.
    output reg irq_out,
    output reg wake_out,
    output reg compare_event_out,
    output reg osc_run_out
);
    // Reset release chain.
    reg rst_meta_reg;
    reg rst_n;

    // Control bits.
    reg counter_on_bit;
    reg sync_bypass;
    reg crystal_osc_enable;
    reg [1:0] clock_source_select;
    reg cmp1_sync_opt;
    reg cmp2_sync_opt;
    reg gate_enable_bit;
    reg gate_polarity;
    reg gate_toggle_mode;
    reg gate_single_pulse_mode;
    reg pulse_arm_flag;
    reg [1:0] gate_source_select;

    // Flags and enables.
    reg overflow_flag;
    reg gate_event_flag;
    reg overflow_irq_enable;
    reg gate_event_irq_enable;
    reg peripheral_irq_enable;
    reg global_irq_enable;

    // Counter and time-base registers.
    reg [15:0] count_reg;
    reg [15:0] capture_compare_pair;
    reg [15:0] compare_reg;
    reg match_d_reg;
    reg [1:0] div_reg;
    reg ext_d1_reg;
    reg ext_d2_reg;
    reg [7:0] t0_d_reg;
    reg t0_pulse_reg;
    reg cmp1_lat_reg;
    reg cmp2_lat_reg;
    reg val_d_reg;

    // Bus state.
    reg aw_got_reg;
    reg w_got_reg;
    reg [`GST_AW-1:0] awaddr_reg;
    reg [31:0] wdata_reg;
    reg [3:0] wstrb_reg;

    wire [3:0] pins_s;
    wire ext_s;
    wire pin_s;
    wire cmp1_s;
    wire cmp2_s;
    wire gate_level_status;
    wire arm_clr;
    reg clk_tick;

    // Merges written byte lanes.
    function [15:0] gst_merge;
        input [15:0] old;
        input [31:0] d;
        input [3:0] s;
        begin
            gst_merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
        end
    endfunction

    // Tells whether an address names a register.
    function gst_hit;
        input [`GST_AW-1:0] a;
        begin
            case (a)
                `GST_A_CTRL, `GST_A_GATE, `GST_A_CNT, `GST_A_FLAG,
                `GST_A_IEN, `GST_A_CAPT, `GST_A_CMPR: gst_hit = 1'b1;
                default: gst_hit = 1'b0;
            endcase
        end
    endfunction

    // Register as software reads it.
    function [15:0] gst_view;
        input [`GST_AW-1:0] a;
        begin
            gst_view = 16'h0000;
            case (a)
                `GST_A_CTRL: begin
                    gst_view[`GST_C_ON] = counter_on_bit;
                    gst_view[`GST_C_BYP] = sync_bypass;
                    gst_view[`GST_C_XOSC] = crystal_osc_enable;
                    gst_view[`GST_C_CSH:`GST_C_CSL] = clock_source_select;
                    gst_view[`GST_C_C1S] = cmp1_sync_opt;
                    gst_view[`GST_C_C2S] = cmp2_sync_opt;
                end
                `GST_A_GATE: begin
                    gst_view[`GST_G_EN] = gate_enable_bit;
                    gst_view[`GST_G_POL] = gate_polarity;
                    gst_view[`GST_G_TM] = gate_toggle_mode;
                    gst_view[`GST_G_SPM] = gate_single_pulse_mode;
                    gst_view[`GST_G_ARM] = pulse_arm_flag;
                    gst_view[`GST_G_VAL] = gate_level_status;
                    gst_view[`GST_G_SSH:`GST_G_SSL] = gate_source_select;
                end
                `GST_A_CNT: gst_view = count_reg;
                `GST_A_FLAG: begin
                    gst_view[`GST_F_OVF] = overflow_flag;
                    gst_view[`GST_F_GEV] = gate_event_flag;
                end
                `GST_A_IEN: begin
                    gst_view[`GST_E_OVF] = overflow_irq_enable;
                    gst_view[`GST_E_GEV] = gate_event_irq_enable;
                    gst_view[`GST_E_PE] = peripheral_irq_enable;
                    gst_view[`GST_E_GIE] = global_irq_enable;
                end
                `GST_A_CAPT: gst_view = capture_compare_pair;
                `GST_A_CMPR: gst_view = compare_reg;
                default: gst_view = 16'h0000;
            endcase
        end
    endfunction

    // Internal reset, released in two stages.
    always @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rst_meta_reg <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n <= rst_meta_reg;
        end
    end

    // Every pin input passes two flip-flops first.
    gst_sync2 #(
        .W(4)
    ) u_sync (
        .clk_in(core_clk_in),
        .rst_n_in(rst_n),
        .async_in({cmp2_in, cmp1_in, gate_pin_in, ext_clk_in}),
        .sync_out(pins_s)
    );

    assign ext_s = pins_s[0];
    assign pin_s = pins_s[1];
    assign cmp1_s = pins_s[2];
    assign cmp2_s = pins_s[3];

    // Write channel bookkeeping.
    wire aw_hs = s_axi_awvalid_in & s_axi_awready_out;
    wire w_hs = s_axi_wvalid_in & s_axi_wready_out;
    wire wr_do = (aw_got_reg | aw_hs) & (w_got_reg | w_hs) & ~s_axi_bvalid_out;
    wire [`GST_AW-1:0] wa = aw_got_reg ? awaddr_reg : s_axi_awaddr_in;
    wire [31:0] wd = w_got_reg ? wdata_reg : s_axi_wdata_in;
    wire [3:0] ws = w_got_reg ? wstrb_reg : s_axi_wstrb_in;
    wire [15:0] wv = gst_merge(gst_view(wa), wd, ws);
    wire wr_ctrl = wr_do & (wa == `GST_A_CTRL);
    wire wr_gate = wr_do & (wa == `GST_A_GATE);
    wire wr_cnt = wr_do & (wa == `GST_A_CNT);
    wire wr_flag = wr_do & (wa == `GST_A_FLAG) & ws[0];
    wire wr_ien = wr_do & (wa == `GST_A_IEN);
    wire wr_cmpr = wr_do & (wa == `GST_A_CMPR);

    // Pin clock edge; sync mode adds a stage.
    wire ext_tick = sync_bypass ? (ext_s & ~ext_d1_reg)
                                : (ext_d1_reg & ~ext_d2_reg);

    // Counting source.
    always @* begin
        case (clock_source_select)
            `GST_CS_INSTR: clk_tick = (div_reg == `GST_DIV_LAST);
            `GST_CS_SYS: clk_tick = 1'b1;
            default: clk_tick = ext_tick;
        endcase
    end

    // Sleep leaves only the unsynchronised pin clock.
    wire ext_async = clock_source_select[1] & sync_bypass;
    wire run_ok = counter_on_bit & (~sleep_in | ext_async);
    wire cnt_en = run_ok & (~gate_enable_bit | gate_level_status);
    wire inc = clk_tick & cnt_en;
    wire wrap = inc & (count_reg == `GST_CNT_MAX) & ~wr_cnt;
    wire gate_fall = val_d_reg & ~gate_level_status;

    // Comparators optionally latched on count ticks.
    wire cmp1_g = cmp1_sync_opt ? cmp1_lat_reg : cmp1_s;
    wire cmp2_g = cmp2_sync_opt ? cmp2_lat_reg : cmp2_s;

    gst_gate u_gate (
        .clk_in(core_clk_in),
        .rst_n_in(rst_n),
        .sel_in(gate_source_select),
        .pin_in(pin_s),
        .t0_in(t0_pulse_reg),
        .cmp1_in(cmp1_g),
        .cmp2_in(cmp2_g),
        .on_in(counter_on_bit),
        .pol_in(gate_polarity),
        .tm_in(gate_toggle_mode),
        .spm_in(gate_single_pulse_mode),
        .arm_in(pulse_arm_flag),
        .val_out(gate_level_status),
        .arm_clr_out(arm_clr)
    );

    // AXI4-Lite slave handshakes and responses.
    always @(posedge core_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_awready_out <= 1'b1;
            s_axi_wready_out <= 1'b1;
            s_axi_bvalid_out <= 1'b0;
            s_axi_bresp_out <= `GST_RESP_OK;
            s_axi_arready_out <= 1'b1;
            s_axi_rvalid_out <= 1'b0;
            s_axi_rdata_out <= 32'h00000000;
            s_axi_rresp_out <= `GST_RESP_OK;
            aw_got_reg <= 1'b0;
            w_got_reg <= 1'b0;
            awaddr_reg <= {`GST_AW{1'b0}};
            wdata_reg <= 32'h00000000;
            wstrb_reg <= 4'h0;
        end else begin
            if (wr_do) begin
                aw_got_reg <= 1'b0;
                w_got_reg <= 1'b0;
                s_axi_awready_out <= 1'b1;
                s_axi_wready_out <= 1'b1;
                s_axi_bvalid_out <= 1'b1;
                s_axi_bresp_out <= gst_hit(wa) ? `GST_RESP_OK : `GST_RESP_ERR;
            end else begin
                if (aw_hs) begin
                    aw_got_reg <= 1'b1;
                    awaddr_reg <= s_axi_awaddr_in;
                    s_axi_awready_out <= 1'b0;
                end
                if (w_hs) begin
                    w_got_reg <= 1'b1;
                    wdata_reg <= s_axi_wdata_in;
                    wstrb_reg <= s_axi_wstrb_in;
                    s_axi_wready_out <= 1'b0;
                end
                if (s_axi_bvalid_out && s_axi_bready_in) begin
                    s_axi_bvalid_out <= 1'b0;
                end
            end
            if (s_axi_arvalid_in && s_axi_arready_out) begin
                s_axi_arready_out <= 1'b0;
                s_axi_rvalid_out <= 1'b1;
                s_axi_rdata_out <= {16'h0000, gst_view(s_axi_araddr_in)};
                s_axi_rresp_out <= gst_hit(s_axi_araddr_in) ? `GST_RESP_OK
                                                            : `GST_RESP_ERR;
            end else if (s_axi_rvalid_out && s_axi_rready_in) begin
                s_axi_rvalid_out <= 1'b0;
                s_axi_arready_out <= 1'b1;
            end
        end
    end

    // Settings; hardware also clears the arm flag.
    always @(posedge core_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            counter_on_bit <= 1'b0;
            sync_bypass <= 1'b0;
            crystal_osc_enable <= 1'b0;
            clock_source_select <= `GST_CS_INSTR;
            cmp1_sync_opt <= 1'b0;
            cmp2_sync_opt <= 1'b0;
            gate_enable_bit <= 1'b0;
            gate_polarity <= 1'b0;
            gate_toggle_mode <= 1'b0;
            gate_single_pulse_mode <= 1'b0;
            pulse_arm_flag <= 1'b0;
            gate_source_select <= `GST_GS_PIN;
            overflow_irq_enable <= 1'b0;
            gate_event_irq_enable <= 1'b0;
            peripheral_irq_enable <= 1'b0;
            global_irq_enable <= 1'b0;
            compare_reg <= `GST_CNT_RST;
        end else begin
            if (wr_ctrl) begin
                counter_on_bit <= wv[`GST_C_ON];
                sync_bypass <= wv[`GST_C_BYP];
                crystal_osc_enable <= wv[`GST_C_XOSC];
                clock_source_select <= wv[`GST_C_CSH:`GST_C_CSL];
                cmp1_sync_opt <= wv[`GST_C_C1S];
                cmp2_sync_opt <= wv[`GST_C_C2S];
            end
            if (wr_gate) begin
                gate_enable_bit <= wv[`GST_G_EN];
                gate_polarity <= wv[`GST_G_POL];
                gate_toggle_mode <= wv[`GST_G_TM];
                gate_single_pulse_mode <= wv[`GST_G_SPM];
                gate_source_select <= wv[`GST_G_SSH:`GST_G_SSL];
            end
            if (wr_gate && wv[`GST_G_ARM]) begin
                pulse_arm_flag <= 1'b1;
            end else if (arm_clr || (wr_gate && ws[0])) begin
                pulse_arm_flag <= 1'b0;
            end
            if (wr_ien) begin
                overflow_irq_enable <= wv[`GST_E_OVF];
                gate_event_irq_enable <= wv[`GST_E_GEV];
                peripheral_irq_enable <= wv[`GST_E_PE];
                global_irq_enable <= wv[`GST_E_GIE];
            end
            if (wr_cmpr) begin
                compare_reg <= wv;
            end
        end
    end

    // Counter, flags and outputs.
    always @(posedge core_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            count_reg <= `GST_CNT_RST;
            capture_compare_pair <= `GST_CNT_RST;
            div_reg <= 2'h0;
            ext_d1_reg <= 1'b0;
            ext_d2_reg <= 1'b0;
            t0_d_reg <= `GST_T0_ZERO;
            t0_pulse_reg <= 1'b0;
            cmp1_lat_reg <= 1'b0;
            cmp2_lat_reg <= 1'b0;
            val_d_reg <= 1'b0;
            match_d_reg <= 1'b0;
            overflow_flag <= 1'b0;
            gate_event_flag <= 1'b0;
            irq_out <= 1'b0;
            wake_out <= 1'b0;
            compare_event_out <= 1'b0;
            osc_run_out <= 1'b0;
        end else begin
            div_reg <= div_reg + 2'h1;
            ext_d1_reg <= ext_s;
            ext_d2_reg <= ext_d1_reg;
            t0_d_reg <= small_timer_count_in;
            t0_pulse_reg <= (t0_d_reg == `GST_T0_MAX)
                            & (small_timer_count_in == `GST_T0_ZERO);
            if (clk_tick) begin
                cmp1_lat_reg <= cmp1_s;
                cmp2_lat_reg <= cmp2_s;
            end
            val_d_reg <= gate_level_status;
            // A write wins over an increment.
            if (wr_cnt) begin
                count_reg <= wv;
            end else if (inc) begin
                count_reg <= count_reg + 16'h0001;
            end
            if (capture_evt_in) begin
                capture_compare_pair <= count_reg;
            end
            match_d_reg <= (count_reg == compare_reg);
            compare_event_out <= (count_reg == compare_reg) & ~match_d_reg;
            // Hardware set wins over a clear.
            if (wrap) begin
                overflow_flag <= 1'b1;
            end else if (wr_flag && wd[`GST_F_OVF]) begin
                overflow_flag <= 1'b0;
            end
            if (gate_fall) begin
                gate_event_flag <= 1'b1;
            end else if (wr_flag && wd[`GST_F_GEV]) begin
                gate_event_flag <= 1'b0;
            end
            irq_out <= peripheral_irq_enable & global_irq_enable
                       & ((overflow_flag & overflow_irq_enable)
                       | (gate_event_flag & gate_event_irq_enable));
            wake_out <= sleep_in & peripheral_irq_enable
                        & overflow_flag & overflow_irq_enable;
            osc_run_out <= crystal_osc_enable;
        end
    end
endmodule

// ===== design/gst_timer_consts.vh
// Contract
// - Sync bypass counts the pin clock without the extra aligning stage.
// - Unsynchronised pin clock counts in sleep; overflow can wake.
// - Count reads while running return a coherent value.
// - Mode switches may lose or add one increment.
// - Gating enabled: count while gate active, else hold.
// - Polarity 0 counts on low gate, 1 on high gate.
// - Gate source 00 pin, 01 small timer wrap, 10/11 comparator 1/2.
// - Small timer FF to 00 step pulses the gate source.
// - Comparator gate inputs are latched on count ticks or passed, per option.
// - Toggle mode flips a flip-flop per source rising edge.
// - Toggle flip-flop is held clear while toggle mode is off.
// - Armed single pulse counts from next active edge, disarms after.
// - Gate level status is readable even with gating disabled.
// - Falling gate level sets the event flag; enabled, it interrupts.
// - Count wrap FFFF to 0000 sets the sticky overflow flag.
// - In sleep only unsynchronised pin mode counts; overflow wakes.
// - Crystal oscillator runs in sleep whatever the sync setting.
// - Count is captured on an event and compared for equality.
// - Off ignores gate enable, stops counting, clears gate flip-flop.
`ifndef GST_TIMER_CONSTS_VH
`define GST_TIMER_CONSTS_VH
`define GST_AW 8
`define GST_A_CTRL 8'h00
`define GST_A_GATE 8'h04
`define GST_A_CNT 8'h08
`define GST_A_FLAG 8'h0C
`define GST_A_IEN 8'h10
`define GST_A_CAPT 8'h14
`define GST_A_CMPR 8'h18
`define GST_C_ON 0
`define GST_C_BYP 2
`define GST_C_XOSC 3
`define GST_C_CSL 6
`define GST_C_CSH 7
`define GST_C_C1S 8
`define GST_C_C2S 9
`define GST_G_SSL 0
`define GST_G_SSH 1
`define GST_G_VAL 2
`define GST_G_ARM 3
`define GST_G_SPM 4
`define GST_G_TM 5
`define GST_G_POL 6
`define GST_G_EN 7
`define GST_F_OVF 0
`define GST_F_GEV 1
`define GST_E_OVF 0
`define GST_E_GEV 1
`define GST_E_PE 6
`define GST_E_GIE 7
`define GST_CS_INSTR 2'h0
`define GST_CS_SYS 2'h1
`define GST_GS_PIN 2'h0
`define GST_GS_T0 2'h1
`define GST_GS_C1 2'h2
`define GST_GS_C2 2'h3
`define GST_CNT_MAX 16'hFFFF
`define GST_CNT_RST 16'h0000
`define GST_T0_MAX 8'hFF
`define GST_T0_ZERO 8'h00
`define GST_DIV_LAST 2'h3
`define GST_RESP_OK 2'h0
`define GST_RESP_ERR 2'h2
`endif

// ===== verification/gst_far_model.sv
module gst_far_model (
    // Frame request from the bench.
    input wire run_in,
    // Count clock pin.
    output logic ext_clk_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // The pin clock runs at 80 ns only within a frame and rests low outside it.
    initial begin
        ext_clk_out = 1'b0;
        #1.3;
        forever begin
            #40;
            if (run_in || ext_clk_out) ext_clk_out = ~ext_clk_out;
        end
    end
endmodule

// ===== verification/gst_timer_props.sv
module gst_timer_props (
    input wire core_clk_in, input wire rstn_in,
    input wire s_axi_awvalid_in, input wire s_axi_awready_out,
    input wire s_axi_wvalid_in, input wire s_axi_wready_out,
    input wire s_axi_bvalid_out, input wire s_axi_bready_in,
    input wire s_axi_arvalid_in, input wire s_axi_arready_out,
    input wire s_axi_rvalid_out, input wire s_axi_rready_in,
    input wire [31:0] s_axi_rdata_out, input wire [1:0] s_axi_rresp_out,
    input wire sleep_in, input wire wake_out,
    input wire compare_event_out, input wire osc_run_out
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!rstn_in);
    b_hold_a: assert property (s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out)
        else $error("bvalid dropped");
    r_hold_a: assert property (s_axi_rvalid_out && !s_axi_rready_in
        |=> s_axi_rvalid_out && $stable(s_axi_rdata_out)) else $error("rdata moved");
    ar_block_a: assert property (s_axi_rvalid_out |-> !s_axi_arready_out)
        else $error("arready open");
    r_lat_a: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
        else $error("read late");
    b_lat_a: assert property (s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in
        && s_axi_wready_out |=> s_axi_bvalid_out) else $error("write late");
    err_data_a: assert property (s_axi_rvalid_out && s_axi_rresp_out == 2'h2
        |-> s_axi_rdata_out == 32'h00000000) else $error("error data");
    wake_sleep_a: assert property (wake_out |-> $past(sleep_in))
        else $error("wake awake");
    cmp_pulse_a: assert property (compare_event_out |=> !compare_event_out)
        else $error("compare long");
    osc_sleep_a: assert property ($rose(sleep_in) |=> $stable(osc_run_out))
        else $error("osc moved");
endmodule

// ===== verification/tb_top.sv
`include "gst_timer_consts.vh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rstn = 0, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
    logic run = 0, pin = 0, c1 = 0, c2 = 0, slp = 0, cev = 0;
    logic [7:0] aw = 0, ar = 0, t0 = 0;
    logic [31:0] wd = 0, rd;
    logic [1:0] rr;
    wire awr, wrdy, bv, arr, rv, irq, wake, cmpe, osc, xclk;
    wire [1:0] br, rresp;
    wire [31:0] rdata;
    int num_errors = 0, compares = 0, cyc = 0;
    gst_timer gst_timer_i (.core_clk_in(clk), .rstn_in(rstn),
        .s_axi_awvalid_in(awv), .s_axi_awready_out(awr), .s_axi_awaddr_in(aw),
        .s_axi_awprot_in(3'h0), .s_axi_wvalid_in(wv), .s_axi_wready_out(wrdy),
        .s_axi_wdata_in(wd), .s_axi_wstrb_in(4'hF), .s_axi_bvalid_out(bv),
        .s_axi_bready_in(bready), .s_axi_bresp_out(br), .s_axi_arvalid_in(arv),
        .s_axi_arready_out(arr), .s_axi_araddr_in(ar), .s_axi_arprot_in(3'h0),
        .s_axi_rvalid_out(rv), .s_axi_rready_in(rready), .s_axi_rdata_out(rdata),
        .s_axi_rresp_out(rresp), .ext_clk_in(xclk), .gate_pin_in(pin), .cmp1_in(c1),
        .cmp2_in(c2), .sleep_in(slp), .small_timer_count_in(t0), .capture_evt_in(cev),
        .irq_out(irq), .wake_out(wake), .compare_event_out(cmpe), .osc_run_out(osc));
    gst_far_model gst_far_model_i (.run_in(run), .ext_clk_out(xclk));
    initial forever #2 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            final_report;
        end
    end
    task final_report;
        if (num_errors == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task chk(input [31:0] s, input [31:0] e, input string n);
        compares++;
        if (s !== e) begin
            num_errors++;
            $display("FAIL %s exp %h got %h", n, e, s);
        end
    endtask
    task wt(input int n);
        repeat (n) @(posedge clk);
    endtask
    task wr(input [7:0] a, input [31:0] d);
        logic pa, pw;
        {pa, pw} = 2'h3;
        @(posedge clk);
        {awv, wv, bready} <= 3'h7;
        aw <= a;
        wd <= d;
        while (pa || pw) begin
            @(posedge clk);
            if (pa && awr) begin pa = 0; awv <= 0; end
            if (pw && wrdy) begin pw = 0; wv <= 0; end
        end
        do @(posedge clk); while (!bv);
        bready <= 0;
    endtask
    task rdr(input [7:0] a);
        @(posedge clk);
        arv <= 1;
        ar <= a;
        rready <= 1;
        do @(posedge clk); while (!arr);
        arv <= 0;
        do @(posedge clk); while (!rv);
        rd = rdata;
        rr = rresp;
        rready <= 0;
    endtask
    task wrap;
        @(posedge clk) t0 <= 8'hFF;
        @(posedge clk) t0 <= 8'h00;
        wt(6);
    endtask
    task t_off;
        wr(`GST_A_CTRL, 32'h0);
        wr(`GST_A_CNT, 32'h1234);
        wt(10);
        rdr(`GST_A_CNT); chk(rd, 32'h1234, "stopped");
        @(posedge clk) cev <= 1;
        @(posedge clk) cev <= 0;
        wt(2);
        rdr(`GST_A_CAPT); chk(rd, 32'h1234, "capture");
        rdr(8'h1C); chk({30'h0, rr}, 32'h2, "unmapped");
    endtask
    task t_ovf;
        wr(`GST_A_CNT, 32'hFFF0);
        wr(`GST_A_FLAG, 32'h3);
        wr(`GST_A_IEN, 32'hC1);
        wr(`GST_A_CTRL, 32'h41);
        wt(20);
        rdr(`GST_A_FLAG); chk(rd[0], 1, "ovf flag");
        chk(irq, 1, "irq");
        wr(`GST_A_FLAG, 32'h1);
        rdr(`GST_A_FLAG); chk(rd[0], 0, "ovf clear");
        wt(2); chk(irq, 0, "irq clear");
    endtask
    task t_gate;
        wr(`GST_A_GATE, 32'hC0);
        wr(`GST_A_CNT, 32'h100);
        wt(10);
        rdr(`GST_A_CNT); chk(rd, 32'h100, "gate hold");
        rdr(`GST_A_GATE); chk(rd[2], 0, "level low");
        @(posedge clk) pin <= 1;
        wt(10);
        rdr(`GST_A_CNT); chk(rd[15:0] != 16'h100, 1, "gate count");
        rdr(`GST_A_GATE); chk(rd[2], 1, "level high");
        wr(`GST_A_FLAG, 32'h3);
        @(posedge clk) pin <= 0;
        wt(8);
        rdr(`GST_A_FLAG); chk(rd[1], 1, "gate event");
        wr(`GST_A_GATE, 32'h80);
        @(posedge clk) pin <= 1;
        wt(6);
        wr(`GST_A_CNT, 32'h200);
        wt(10);
        rdr(`GST_A_CNT); chk(rd, 32'h200, "pol low hold");
        wr(`GST_A_GATE, 32'h40);
        rdr(`GST_A_GATE); chk(rd[2], 1, "ungated");
    endtask
    task t_src;
        for (int i = 0; i < 4; i++) begin
            @(posedge clk) begin pin <= (i == 0); c1 <= (i == 2); c2 <= (i == 3); end
            wr(`GST_A_GATE, 32'hC0 | i);
            wt(8);
            rdr(`GST_A_GATE); chk(rd[2], i != 1, "source");
        end
        wr(`GST_A_GATE, 32'hE1);
        wrap;
        rdr(`GST_A_GATE); chk(rd[2], 1, "toggle set");
        wrap;
        rdr(`GST_A_GATE); chk(rd[2], 0, "toggle back");
        wr(`GST_A_GATE, 32'hC1);
        wrap;
        rdr(`GST_A_GATE); chk(rd[2], 0, "toggle clear");
    endtask
    task t_spm;
        @(posedge clk) pin <= 0;
        wr(`GST_A_GATE, 32'hD0);
        wr(`GST_A_GATE, 32'hD8);
        wr(`GST_A_CNT, 32'h300);
        wt(6);
        rdr(`GST_A_CNT); chk(rd, 32'h300, "armed hold");
        @(posedge clk) pin <= 1;
        wt(10);
        @(posedge clk) pin <= 0;
        wt(8);
        rdr(`GST_A_GATE); chk(rd[3], 0, "disarm");
        wr(`GST_A_CNT, 32'h400);
        @(posedge clk) pin <= 1;
        wt(10);
        rdr(`GST_A_CNT); chk(rd, 32'h400, "blocked");
        wr(`GST_A_GATE, 32'h0);
    endtask
    task t_sleep;
        wr(`GST_A_CTRL, 32'h0);
        wr(`GST_A_CNT, 32'hFFF8);
        wr(`GST_A_FLAG, 32'h3);
        wr(`GST_A_IEN, 32'h41);
        wr(`GST_A_CTRL, 32'h8D);
        @(posedge clk) begin slp <= 1; run <= 1; end
        wt(300);
        chk(wake, 1, "wake");
        chk(irq, 0, "no service");
        chk(osc, 1, "oscillator");
        @(posedge clk) begin slp <= 0; run <= 0; end
        wt(4);
        rdr(`GST_A_FLAG); chk(rd[0], 1, "pin ovf");
    endtask
    initial begin
        wt(5);
        rstn <= 1;
        wt(4);
        t_off;
        t_ovf;
        t_gate;
        t_src;
        t_spm;
        t_sleep;
        final_report;
    end
endmodule
bind gst_timer gst_timer_props gst_timer_props_i (.core_clk_in, .rstn_in,
    .s_axi_awvalid_in, .s_axi_awready_out, .s_axi_wvalid_in, .s_axi_wready_out,
    .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_arvalid_in, .s_axi_arready_out,
    .s_axi_rvalid_out, .s_axi_rready_in, .s_axi_rdata_out, .s_axi_rresp_out,
    .sleep_in, .wake_out, .compare_event_out, .osc_run_out);
